/* shared/sbc_spi_defs.vh */
// Purpose: Constants for the serial register port and status reporting.
// Assumes: 40 MHz system clock, 16-bit frames of command byte then data byte.
// Notes:   Addresses are 7 bits; bit 7 of the command byte selects a write.
`ifndef SBC_SPI_DEFS_VH
`define SBC_SPI_DEFS_VH

// Timing.
`define CLK_PERIOD_NS   25
`define CMD_GAP_NS      3000
`define EXEC_LIMIT_NS   5000

// Frame layout.
`define BYTE_BITS       5'h08
`define FRAME_BITS      5'h10
`define BIT_CNT_MAX     5'h1f
`define CMD_WRITE_BIT   7
`define SYNC_IDLE       3'h2

// Register addresses.
`define ADDR_CTRL       7'h01
`define ADDR_SCRATCH    7'h0f
`define ADDR_PN_FIRST   7'h20
`define ADDR_PN_LAST    7'h23
`define ADDR_WAKE_STAT  7'h40
`define ADDR_SUP_STAT   7'h41
`define ADDR_BUS_STAT_0 7'h43

// Reset values.
`define BYTE_RESET      8'h00

// Status information field bit positions.
`define SIF_WAKE        0
`define SIF_SUP         1
`define SIF_BUS0        3

// Supply status bit positions.
`define SUP_TPW         0
`define SUP_IOW         1
`define SUP_GAP         2

// Bus transceiver status 0 bit positions.
`define BUS0_SUPPLY_UV  0
`define BUS0_THERMAL    1
`define BUS0_BUS_DOM    2
`define BUS0_TXD_DOM    3

`endif

/* hdl/spi_frame_shifter.v */
// Purpose: Serial frame shifter that oversamples the link pins.
// Assumes: Link clock idles low and is much slower than the system clock.
// Notes:   Frames that do not hold exactly sixteen bits are discarded.
`include "sbc_spi_defs.vh"

module spi_frame_shifter (
  // System.
  input  wire       clock,
  input  wire       rst,
  // Link pins.
  input  wire       sclk_pin,
  input  wire       select_line_low_active,
  input  wire       sdi_pin,
  // Data to send.
  input  wire [7:0] status_field,
  input  wire [7:0] read_byte,
  // Link outputs.
  output reg        sdo,
  output reg        sdo_oe,
  // Received frame.
  output reg  [7:0] cmd_byte,
  output reg  [7:0] data_byte,
  output reg        frame_start,
  output reg        frame_done
);

  reg  [2:0] meta;
  reg  [2:0] sync;
  reg        sclk_prev;
  reg        csn_prev;
  reg  [4:0] count;
  reg  [7:0] rx;
  reg  [7:0] tx;
  wire       sclk_fall = sclk_prev & ~sync[2];
  wire       sclk_rise = ~sclk_prev & sync[2];
  wire [7:0] rx_next   = {rx[6:0], sync[0]};

  // Two stages on every pin; only the second stage feeds logic.
  always @(posedge clock) begin
    if (rst) begin
      meta <= `SYNC_IDLE;
      sync <= `SYNC_IDLE;
    end else begin
      meta <= {sclk_pin, select_line_low_active, sdi_pin};
      sync <= meta;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      sclk_prev   <= 1'b0;
      csn_prev    <= 1'b1;
      count       <= 5'h00;
      rx          <= `BYTE_RESET;
      tx          <= `BYTE_RESET;
      sdo         <= 1'b0;
      sdo_oe      <= 1'b0;
      cmd_byte    <= `BYTE_RESET;
      data_byte   <= `BYTE_RESET;
      frame_start <= 1'b0;
      frame_done  <= 1'b0;
    end else begin
      sclk_prev   <= sync[2];
      csn_prev    <= sync[1];
      frame_start <= 1'b0;
      frame_done  <= 1'b0;
      if (csn_prev & ~sync[1]) begin
        count       <= 5'h00;
        tx          <= status_field;
        sdo         <= status_field[7];
        sdo_oe      <= 1'b1;
        frame_start <= 1'b1;
      end else if (~csn_prev & sync[1]) begin
        sdo_oe <= 1'b0;
        sdo    <= 1'b0;
        frame_done <= (count == `FRAME_BITS);
      end else if (~sync[1]) begin
        if (sclk_fall) begin
          rx <= rx_next;
          if (count != `BIT_CNT_MAX) begin
            count <= count + 5'h01;
          end
          if (count == `BYTE_BITS - 5'h01) begin
            cmd_byte <= rx_next;
          end
          if (count == `FRAME_BITS - 5'h01) begin
            data_byte <= rx_next;
          end
        end
        if (sclk_rise) begin
          // most significant first
          // The top bit is already out at select, so the first rise keeps it.
          if (count == `BYTE_BITS) begin
            tx  <= read_byte;
            sdo <= read_byte[7];
          end else if (count != 5'h00) begin
            tx  <= {tx[6:0], 1'b0};
            sdo <= tx[6];
          end
        end
      end
    end
  end

endmodule // spi_frame_shifter

/* hdl/sbc_spi_status_diag.v */
// Purpose: Serial register port with latched diagnosis and status field.
// Assumes: Event and supply inputs come from analog comparators, unsynchronised.
// Notes:   Status flags clear when a one is written to them; prewarnings clear on read.
`include "sbc_spi_defs.vh"

// Contract
// - Execute command within 5 us of deselect.
// - Data sampled on falling link clock edge.
// - Field bit set when its register nonzero.
// - Field sent MSB first, bit 3 bus.
// - Bus status holds four transceiver fault flags.
// - Scratch byte freely written, never changed internally.
// - Wake and failure flags held until cleared.
// - Selective wake registers only with partial networking.
// - Thermal prewarning flag, read clear.
// - I/O supply prewarning flag, read clear.
// - Reset microcontroller while main supply undervoltage.
// - Control registers writable in normal mode.
module sbc_spi_status_diag #(
  parameter HAS_PARTIAL_NET = 1,
  parameter PN_COUNT        = 4
) (
  // System.
  input  wire       clock,
  input  wire       rst,
  // Serial link.
  input  wire       sclk_pin,
  input  wire       select_line_low_active,
  input  wire       sdi_pin,
  output wire       sdo,
  output wire       sdo_oe,
  // Mode from chip state logic, same clock.
  input  wire       normal_mode,
  // Analog event and supply monitors.
  input  wire [3:0] bus_event,
  input  wire [3:0] wake_event,
  input  wire       thermal_prewarn,
  input  wire       io_supply_prewarn,
  input  wire       main_supply_output_uv,
  // Outputs to the chip.
  output reg        mcu_reset_low_active,
  output reg  [7:0] control_out
);

  localparam GAP_CYCLES = (`CMD_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam EXEC_CYCLES = `EXEC_LIMIT_NS / `CLK_PERIOD_NS;
  localparam [7:0] GAP_LOAD = GAP_CYCLES[7:0];

  // Monitor synchronisers.
  reg  [10:0] mon_meta;
  reg  [10:0] mon_sync;
  wire [3:0]  bus_cause  = mon_sync[3:0];
  wire [3:0]  wake_cause = mon_sync[7:4];
  wire        tpw_cause  = mon_sync[8];
  wire        iow_cause  = mon_sync[9];
  wire        uv_level   = mon_sync[10];

  // Register file.
  reg  [7:0]  scratch_ram_register;
  reg  [7:0]  pn_reg [0:PN_COUNT-1];
  reg  [3:0]  wake_stat;
  reg  [3:0]  bus_stat_0;
  reg  [2:0]  sup_stat;
  reg  [7:0]  status_field;
  reg  [7:0]  next_status_field;
  reg  [7:0]  read_byte;
  reg  [7:0]  gap_count;

  // Frame interface.
  wire [7:0]  cmd_byte;
  wire [7:0]  data_byte;
  wire        frame_start;
  wire        frame_done;
  wire [6:0]  addr     = cmd_byte[6:0];
  wire        is_write = cmd_byte[`CMD_WRITE_BIT];
  wire        pn_space = (addr >= `ADDR_PN_FIRST) && (addr <= `ADDR_PN_LAST);
  wire        pn_hit   = pn_space && (HAS_PARTIAL_NET != 0);
  wire [3:0]  w1c_low  = (frame_done && is_write) ? data_byte[3:0] : 4'h0;

  function access;
    input       done;
    input [6:0] cur;
    input [6:0] target;
    begin
      access = done && (cur == target);
    end
  endfunction

  spi_frame_shifter u_shifter (
    .clock                  (clock),
    .rst                    (rst),
    .sclk_pin               (sclk_pin),
    .select_line_low_active (select_line_low_active),
    .sdi_pin                (sdi_pin),
    .status_field           (status_field),
    .read_byte              (read_byte),
    .sdo                    (sdo),
    .sdo_oe                 (sdo_oe),
    .cmd_byte               (cmd_byte),
    .data_byte              (data_byte),
    .frame_start            (frame_start),
    .frame_done             (frame_done)
  );

  always @(posedge clock) begin
    if (rst) begin
      mon_meta <= 11'h000;
      mon_sync <= 11'h000;
    end else begin
      mon_meta <= {main_supply_output_uv, io_supply_prewarn, thermal_prewarn,
                   wake_event, bus_event};
      mon_sync <= mon_meta;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      mcu_reset_low_active <= 1'b0;
    end else begin
      mcu_reset_low_active <= ~uv_level;
    end
  end

  // Writes land in the cycle after deselect is seen, well inside the limit.
  always @(posedge clock) begin
    if (rst) begin
      control_out          <= `BYTE_RESET;
      scratch_ram_register <= `BYTE_RESET;
    end else if (frame_done && is_write) begin
      if (normal_mode && (addr == `ADDR_CTRL)) begin
        control_out <= data_byte;
      end
      if (addr == `ADDR_SCRATCH) begin
        scratch_ram_register <= data_byte;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < PN_COUNT; gi = gi + 1) begin : g_pn
      always @(posedge clock) begin
        if (rst) begin
          pn_reg[gi] <= `BYTE_RESET;
        end else if (frame_done && is_write && pn_hit && (addr[1:0] == gi)) begin
          pn_reg[gi] <= data_byte;
        end
      end
    end
  endgenerate

  // The master owns command spacing; a short gap is latched as a failure.
  always @(posedge clock) begin
    if (rst) begin
      gap_count <= 8'h00;
    end else if (frame_done) begin
      gap_count <= GAP_LOAD;
    end else if (gap_count != 8'h00) begin
      gap_count <= gap_count - 8'h01;
    end
  end

  // Flags: a new cause always beats a clear in the same cycle.
  always @(posedge clock) begin
    if (rst) begin
      wake_stat  <= 4'h0;
      bus_stat_0 <= 4'h0;
      sup_stat   <= 3'h0;
    end else begin
      if (access(frame_done, addr, `ADDR_WAKE_STAT)) begin
        wake_stat <= wake_cause | (wake_stat & ~w1c_low);
      end else begin
        wake_stat <= wake_cause | wake_stat;
      end
      if (access(frame_done, addr, `ADDR_BUS_STAT_0)) begin
        bus_stat_0 <= bus_cause | (bus_stat_0 & ~w1c_low);
      end else begin
        bus_stat_0 <= bus_cause | bus_stat_0;
      end
      if (access(frame_done, addr, `ADDR_SUP_STAT) && !is_write) begin
        sup_stat[`SUP_TPW] <= tpw_cause;
        sup_stat[`SUP_IOW] <= iow_cause;
      end else begin
        sup_stat[`SUP_TPW] <= tpw_cause | sup_stat[`SUP_TPW];
        sup_stat[`SUP_IOW] <= iow_cause | sup_stat[`SUP_IOW];
      end
      if (frame_start && (gap_count != 8'h00)) begin
        sup_stat[`SUP_GAP] <= 1'b1;
      end else if (access(frame_done, addr, `ADDR_SUP_STAT) && is_write &&
                   data_byte[`SUP_GAP]) begin
        sup_stat[`SUP_GAP] <= 1'b0;
      end
    end
  end

  always @* begin
    next_status_field = 8'h00;
    next_status_field[`SIF_WAKE] = |wake_stat;
    next_status_field[`SIF_SUP] = |sup_stat;
    next_status_field[`SIF_BUS0] = |bus_stat_0;
  end

  always @(posedge clock) begin
    if (rst) begin
      status_field <= `BYTE_RESET;
    end else begin
      status_field <= next_status_field;
    end
  end

  // Read data settles long before the next link clock edge needs it.
  always @* begin
    read_byte = `BYTE_RESET;
    case (addr)
      `ADDR_CTRL:       read_byte = control_out;
      `ADDR_SCRATCH:    read_byte = scratch_ram_register;
      `ADDR_WAKE_STAT:  read_byte = {4'h0, wake_stat};
      `ADDR_SUP_STAT:   read_byte = {5'h00, sup_stat};
      `ADDR_BUS_STAT_0: read_byte = {4'h0, bus_stat_0};
      default: begin
        if (pn_hit) begin
          read_byte = pn_reg[addr[1:0]];
        end
      end
    endcase
  end

endmodule // sbc_spi_status_diag

/* dv/sbc_spi_checker.sv */
// Purpose: Port assertions for the serial status port.
// Assumes: Link pins change far slower than the system clock.
// Notes:   Lags allow for the two-stage input synchronisers.
module sbc_spi_checker (
  // System.
  input wire       clock,
  input wire       rst,
  // Link.
  input wire       sclk_pin,
  input wire       select_line_low_active,
  input wire       sdo,
  input wire       sdo_oe,
  // Chip side.
  input wire       normal_mode,
  input wire       main_supply_output_uv,
  input wire       mcu_reset_low_active,
  input wire [7:0] control_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  uv_reset_a: assert property ($rose(main_supply_output_uv)
    |-> ##[1:4] !mcu_reset_low_active)
    else $error("reset late on undervoltage");
  uv_release_a: assert property ($fell(main_supply_output_uv)
    |-> ##[1:4] mcu_reset_low_active)
    else $error("reset not released");
  oe_open_a: assert property ($fell(select_line_low_active) |-> ##[1:5] sdo_oe)
    else $error("output not enabled");
  oe_close_a: assert property ($rose(select_line_low_active) |-> ##[1:5] !sdo_oe)
    else $error("output not released");
  idle_quiet_a: assert property (select_line_low_active [*6] |-> !sdo_oe && !sdo)
    else $error("output active while idle");
  field_lead_a: assert property ($rose(sdo_oe) |-> !sdo)
    else $error("field top bit set");
  shift_edge_a: assert property (sdo_oe && $past(sdo_oe) && $changed(sdo)
    |-> $past(sclk_pin, 2))
    else $error("data moved off the rising edge");
  ctrl_gate_a: assert property ($changed(control_out)
    |-> $past(normal_mode) && $past(select_line_low_active, 4))
    else $error("control changed outside a write");
endmodule // sbc_spi_checker

bind sbc_spi_status_diag sbc_spi_checker i_sbc_spi_checker (.clock, .rst, .sclk_pin,
  .select_line_low_active, .sdo, .sdo_oe, .normal_mode, .main_supply_output_uv,
  .mcu_reset_low_active, .control_out);

/* dv/spi_master_model.sv */
// Purpose: Serial master that runs frames on the link pins.
// Assumes: Link clock idles low with a 200 ns period.
// Notes:   Between frames the data line shows the inverse of its last bit.
module spi_master_model (
  // Link.
  output logic sclk_pin,
  output logic select_line_low_active,
  output logic sdi_pin,
  input  wire  sdo
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclk_pin = 1'b0;
    select_line_low_active = 1'b1;
    sdi_pin = 1'b0;
  end
  task automatic xfer(input logic [15:0] tx, input int nbits, input int gap_ns,
                      output logic [15:0] rx);
    rx = 16'h0000;
    select_line_low_active = 1'b0;
    #200;
    for (int i = 0; i < nbits; i++) begin
      sdi_pin = tx[15-i];
      sclk_pin = 1'b1;
      #100;
      sclk_pin = 1'b0;
      rx = {rx[14:0], sdo};
      #100;
    end
    select_line_low_active = 1'b1;
    sdi_pin = ~sdi_pin;
    #(gap_ns);
  endtask
endmodule // spi_master_model

/* dv/sbc_spi_status_diag_tb.sv */
// Purpose: Self-checking bench for the serial status port.
// Assumes: The master model paces frames over three microseconds apart, except one 1 us short gap.
// Notes:   Reset checks run first, then table rows, refusal, event, prewarn, gap and supply cases.
module sbc_spi_status_diag_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [15:0] tx; logic [15:0] exp;} frame_row;
  logic        clock;
  logic        rst;
  logic        normal_mode;
  logic        thermal_prewarn;
  logic        io_supply_prewarn;
  logic        main_supply_output_uv;
  logic [3:0]  bus_event;
  logic [3:0]  wake_event;
  logic [15:0] rx;
  logic [7:0]  exp_sif;
  logic [7:0]  bit_val;
  logic [7:0]  addr;
  wire         sclk_pin;
  wire         select_line_low_active;
  wire         sdi_pin;
  wire         sdo;
  wire         sdo_oe;
  wire         mcu_reset_low_active;
  wire [7:0]   control_out;
  wire [15:0]  chip_out = {control_out, 7'h00, mcu_reset_low_active};
  int          bad_count;
  int          checks;
  frame_row    rows [7] = '{'{16'h8fa5, 16'h0000}, '{16'h0f00, 16'h00a5},
    '{16'h7e00, 16'h0000}, '{16'ha055, 16'h0000}, '{16'h2000, 16'h0055},
    '{16'h0100, 16'h0000}, '{16'h813c, 16'h0000}};

  sbc_spi_status_diag i_sbc_spi_status_diag (.clock, .rst, .sclk_pin, .select_line_low_active,
    .sdi_pin, .sdo, .sdo_oe, .normal_mode, .bus_event, .wake_event, .thermal_prewarn,
    .io_supply_prewarn, .main_supply_output_uv, .mcu_reset_low_active, .control_out);
  spi_master_model i_spi_master_model (.sclk_pin, .select_line_low_active, .sdi_pin, .sdo);

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic frame(input logic [15:0] tx, input logic [15:0] exp);
    i_spi_master_model.xfer(tx, 16, 3200, rx);
    check("frame", rx, exp);
  endtask
  task automatic wrap_up();
    $display("Counts: %0d checks, %0d mismatches", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    repeat (40000) @(posedge clock);
    bad_count++;
    $display("Error watchdog expected finish seen hang");
    wrap_up();
  end
  initial begin
    rst = 1'b1;
    normal_mode = 1'b1;
    bus_event = 4'h0;
    wake_event = 4'h0;
    thermal_prewarn = 1'b0;
    io_supply_prewarn = 1'b0;
    main_supply_output_uv = 1'b0;
    repeat (16) @(negedge clock);
    check("reset", chip_out, 16'h0000);
    rst = 1'b0;
    repeat (8) @(negedge clock);
    check("release", chip_out, 16'h0001);
    $display("Test reset done");
    foreach (rows[i]) frame(rows[i].tx, rows[i].exp);
    check("control", chip_out, 16'h3c01);
    normal_mode = 1'b0;
    frame(16'h81ff, 16'h003c);
    check("control", chip_out, 16'h3c01);
    normal_mode = 1'b1;
    i_spi_master_model.xfer(16'h8fff, 12, 3200, rx);
    frame(16'h0f00, 16'h00a5);
    $display("Test table done");
    for (int j = 0; j < 8; j++) begin
      if (j < 4)
        bus_event[j] = 1'b1;
      else
        wake_event[j-4] = 1'b1;
      repeat (4) @(negedge clock);
      bus_event = 4'h0;
      wake_event = 4'h0;
      exp_sif = (j < 4) ? 8'h08 : 8'h01;
      bit_val = 8'h01 << (j % 4);
      addr = (j < 4) ? 8'h43 : 8'h40;
      frame({addr, 8'h00}, {exp_sif, bit_val});
      frame({addr | 8'h80, bit_val}, {exp_sif, bit_val});
      frame({addr, 8'h00}, 16'h0000);
    end
    $display("Test events done");
    for (int k = 0; k < 2; k++) begin
      thermal_prewarn = (k == 0);
      io_supply_prewarn = (k == 1);
      bit_val = 8'h01 << k;
      repeat (4) @(negedge clock);
      frame(16'h4100, {8'h02, bit_val});
      thermal_prewarn = 1'b0;
      io_supply_prewarn = 1'b0;
      frame(16'h4100, {8'h02, bit_val});
      frame(16'h4100, 16'h0000);
    end
    $display("Test prewarn done");
    // A frame that starts too soon after the last is latched as a gap fault.
    i_spi_master_model.xfer(16'h0100, 16, 1000, rx);
    check("short gap", rx, 16'h003c);
    frame(16'h4100, 16'h0004);
    frame(16'hc104, 16'h0204);
    frame(16'h4100, 16'h0000);
    $display("Test gap done");
    main_supply_output_uv = 1'b1;
    repeat (5) @(negedge clock);
    check("uv", chip_out, 16'h3c00);
    main_supply_output_uv = 1'b0;
    repeat (5) @(negedge clock);
    check("uv", chip_out, 16'h3c01);
    $display("Test supply done");
    wrap_up();
  end
endmodule // sbc_spi_status_diag_tb
